// *** vcsp_pkg.sv ***
/*
  Package for the common-voltage setting serial port: bus addresses, frame
  layout, reset values and timing counts.
  Assumes a 100 MHz system clock and a bus master at 100 or 400 kbit/s.
*/
package vcsp_pkg;

  // ----------------------------------------------------------------------
  // Bus address and frame layout
  // ----------------------------------------------------------------------
  localparam logic [6:0] VCSP_SLAVE_ADDR  = 7'h4f;   // 9Eh write, 9Fh read
  localparam int         VCSP_CODE_MSB    = 7;
  localparam int         VCSP_CODE_LSB    = 1;
  localparam int         VCSP_FLAG_BIT    = 0;
  localparam logic       VCSP_FLAG_BOTH   = 1'b0;    // Volatile and stored
  localparam logic       VCSP_FLAG_DIFFER = 1'b1;    // Read: copies differ

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [6:0] VCSP_CODE_RESET  = 7'h00;

  // ----------------------------------------------------------------------
  // Storage write busy time
  // ----------------------------------------------------------------------
  localparam int VCSP_CLK_MHZ        = 100;
  localparam int VCSP_NV_WRITE_US    = 100;
  localparam int VCSP_NV_WRITE_CYC   = VCSP_NV_WRITE_US * VCSP_CLK_MHZ;

  // Bus controller states
  typedef enum logic [2:0] {
    VCSP_IDLE  = 3'b000,
    VCSP_ADDR  = 3'b001,
    VCSP_AACK  = 3'b010,
    VCSP_WDATA = 3'b011,
    VCSP_WACK  = 3'b100,
    VCSP_RDATA = 3'b101,
    VCSP_RACK  = 3'b110
  } vcsp_state_t;

endpackage

// *** vcsp_nv_if.sv ***
/*
  Interface carrying a storage write request and its busy answer between
  the bus controller and the non-volatile store model.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface vcsp_nv_if;
  logic       wr_req;
  logic [6:0] wr_code;
  logic       busy;
  logic [6:0] stored_code;
  modport ctrl  (output wr_req, output wr_code, input busy, input stored_code);
  modport store (input wr_req, input wr_code, output busy, output stored_code);
endinterface

// *** vcsp_nv_store.sv ***
/*
  Non-volatile copy of the common voltage code with a timed write cycle.
  Assumes a request pulse only arrives while not busy.
*/
`timescale 1ns/1ps
module vcsp_nv_store
  import vcsp_pkg::*;
#(
  parameter int NV_WRITE_CYC = VCSP_NV_WRITE_CYC
) (
  input  wire logic clk,
  input  wire logic resetn,
  vcsp_nv_if.store  nv
);

  logic [6:0]  code_q;
  logic [31:0] cnt_q;

  // Store the code and count down the write time
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      code_q <= VCSP_CODE_RESET;
      cnt_q  <= 32'h0;
    end else if (nv.wr_req) begin
      code_q <= nv.wr_code;
      cnt_q  <= 32'(NV_WRITE_CYC);
    end else if (cnt_q != 32'h0) begin
      cnt_q  <= cnt_q - 32'h1;
    end
  end

  assign nv.busy        = (cnt_q != 32'h0);
  assign nv.stored_code = code_q;

endmodule

// *** vcsp_top.sv ***
/*
  Serial bus slave that holds the common voltage code, with a timed
  non-volatile copy reached through an interface.
  Assumes scl and sda come from pins; sda is open drain via oe.
*/
// Overview of operation
// R01 - Frame: code bits 7-1, flag bit 0
// R02 - Flag zero writes volatile and stored copies
// R03 - Flag one writes volatile copy only
// R04 - Read flag zero when copies equal
// R05 - Read returns volatile code in bits 7-1
// R06 - Write is address then one data byte
// R07 - Read returns one byte, master NACKs
// R08 - Slave only, 100 and 400 kbit/s
// R09 - Ignore addressing while write completes
// R10 - Leave address ACK high while busy
`timescale 1ns/1ps
module vcsp_top
  import vcsp_pkg::*;
#(
  parameter int NV_WRITE_CYC = VCSP_NV_WRITE_CYC
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  output logic [6:0]      common_voltage_code,
  output logic            busy
);

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  logic [1:0] scl_s_q, sda_s_q;
  logic       scl_p_q, sda_p_q;

  // Two flops per pin, then a history flop
  always_ff @(posedge clk or negedge resetn) begin // R08
    if (!resetn) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end

  wire scl      = scl_s_q[1];
  wire sda      = sda_s_q[1];
  wire scl_rise = scl & ~scl_p_q;
  wire scl_fall = ~scl & scl_p_q;
  wire start_c  = scl & scl_p_q & sda_p_q & ~sda;
  wire stop_c   = scl & scl_p_q & ~sda_p_q & sda;

  // ----------------------------------------------------------------------
  // Bus controller
  // ----------------------------------------------------------------------
  vcsp_nv_if   nv ();
  vcsp_state_t st_q, st_d;
  logic [7:0]  sh_q, sh_d;
  logic [2:0]  bit_q, bit_d;
  logic [6:0]  code_q, code_d;
  logic        drv_q, drv_d;
  logic        req_q, req_d;
  logic [6:0]  wcode_q, wcode_d;

  wire [7:0] sh_in    = {sh_q[6:0], sda};
  wire       addr_hit = (sh_in[7:1] == VCSP_SLAVE_ADDR);
  wire       can_ack  = addr_hit & ~nv.busy & ~req_q;                // R09
  wire       differ   = (code_q != nv.stored_code);
  wire [7:0] rd_byte  = {code_q, differ ? VCSP_FLAG_DIFFER : ~VCSP_FLAG_DIFFER}; // R04 R05

  // Next state and datapath
  always_comb begin
    st_d    = st_q;
    sh_d    = sh_q;
    bit_d   = bit_q;
    code_d  = code_q;
    drv_d   = drv_q;
    req_d   = 1'b0;
    wcode_d = wcode_q;
    if (start_c) begin
      st_d  = VCSP_ADDR;
      bit_d = 3'h0;
      drv_d = 1'b0;
    end else if (stop_c) begin
      st_d  = VCSP_IDLE;
      drv_d = 1'b0;
    end else begin
      unique case (st_q)
        VCSP_IDLE: begin
          drv_d = 1'b0;
        end
        VCSP_ADDR: begin
          if (scl_rise) begin
            sh_d  = sh_in;
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              st_d = can_ack ? VCSP_AACK : VCSP_IDLE;   // R10
            end
          end
        end
        VCSP_AACK: begin
          if (scl_fall && !drv_q) begin
            drv_d = 1'b1;                                // Drive ACK low
          end else if (scl_fall && drv_q) begin
            bit_d = 3'h0;
            if (sh_q[0]) begin
              st_d  = VCSP_RDATA;                        // R07
              sh_d  = rd_byte;
              drv_d = ~rd_byte[7];
            end else begin
              st_d  = VCSP_WDATA;                        // R06
              drv_d = 1'b0;
            end
          end
        end
        VCSP_WDATA: begin
          if (scl_rise) begin
            sh_d  = sh_in;
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              st_d   = VCSP_WACK;
              code_d = sh_in[VCSP_CODE_MSB:VCSP_CODE_LSB];  // R01 R03
              if (sh_in[VCSP_FLAG_BIT] == VCSP_FLAG_BOTH) begin
                req_d   = 1'b1;                         // R02
                wcode_d = sh_in[VCSP_CODE_MSB:VCSP_CODE_LSB];
              end
            end
          end
        end
        VCSP_WACK: begin
          if (scl_fall && !drv_q) begin
            drv_d = 1'b1;
          end else if (scl_fall && drv_q) begin
            drv_d = 1'b0;
            st_d  = VCSP_IDLE;                           // One byte only
          end
        end
        VCSP_RDATA: begin
          if (scl_fall) begin
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              st_d  = VCSP_RACK;
              drv_d = 1'b0;
            end else begin
              sh_d  = {sh_q[6:0], 1'b0};
              drv_d = ~sh_q[6];
            end
          end
        end
        VCSP_RACK: begin
          if (scl_rise) begin
            st_d = VCSP_IDLE;                            // R07
          end
        end
        default: begin
          st_d  = VCSP_IDLE;
          drv_d = 1'b0;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q    <= VCSP_IDLE;
      sh_q    <= 8'h00;
      bit_q   <= 3'h0;
      code_q  <= VCSP_CODE_RESET;
      drv_q   <= 1'b0;
      req_q   <= 1'b0;
      wcode_q <= VCSP_CODE_RESET;
    end else begin
      st_q    <= st_d;
      sh_q    <= sh_d;
      bit_q   <= bit_d;
      code_q  <= code_d;
      drv_q   <= drv_d;
      req_q   <= req_d;
      wcode_q <= wcode_d;
    end
  end

  assign nv.wr_req  = req_q;
  assign nv.wr_code = wcode_q;

  // ----------------------------------------------------------------------
  // Non-volatile copy
  // ----------------------------------------------------------------------
  vcsp_nv_store #(
    .NV_WRITE_CYC (NV_WRITE_CYC)
  ) u_store (
    .clk    (clk),
    .resetn (resetn),
    .nv     (nv.store)
  );

  // Open-drain pin: drive low only
  assign sda_o               = 1'b0;
  assign sda_oe              = drv_q;
  assign common_voltage_code = code_q;
  assign busy                = nv.busy;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  busy_noack_a: assert property (@(posedge clk) disable iff (!resetn) // R09
    (st_q == VCSP_ADDR && st_d == VCSP_AACK) |-> !nv.busy && !req_q)
    else $error("address acknowledged while busy");

  // A refused address goes back to idle with the pin released
  busy_release_a: assert property (@(posedge clk) disable iff (!resetn) // R10
    (st_q == VCSP_ADDR && scl_rise && bit_q == 3'h7 && nv.busy)
      |=> st_q == VCSP_IDLE && !drv_q)
    else $error("ack driven while busy");

  nv_write_a: assert property (@(posedge clk) disable iff (!resetn) // R02
    req_q |=> (nv.stored_code == $past(wcode_q)) && nv.busy)
    else $error("stored copy not written");

  nv_keep_a: assert property (@(posedge clk) disable iff (!resetn) // R03
    (!req_q) |=> $stable(nv.stored_code))
    else $error("stored copy changed without request");

  code_load_a: assert property (@(posedge clk) disable iff (!resetn) // R01
    (st_q == VCSP_WDATA && st_d == VCSP_WACK)
      |=> code_q == $past(sh_in[VCSP_CODE_MSB:VCSP_CODE_LSB]))
    else $error("volatile code not loaded");

  rd_code_a: assert property (@(posedge clk) disable iff (!resetn) // R05
    (st_q == VCSP_AACK && st_d == VCSP_RDATA) |=> sh_q[7:1] == code_q)
    else $error("read byte lacks volatile code");

  rd_flag_a: assert property (@(posedge clk) disable iff (!resetn) // R04
    (st_q == VCSP_AACK && st_d == VCSP_RDATA)
      |=> sh_q[0] == (code_q != nv.stored_code))
    else $error("read flag wrong");

  // Idle covers extra write bytes: they must never be acknowledged
  one_byte_a: assert property (@(posedge clk) disable iff (!resetn) // R06
    (st_q == VCSP_IDLE) |-> !sda_oe)
    else $error("data pin driven while idle");

endmodule

// *** vcsp_master.sv ***
/*
  Bus master model for the common voltage serial port.
  Assumes an open-drain data wire with pull-up resolved by the bench.
*/
`timescale 1ns/1ps
module vcsp_master (
  input  wire logic clk,
  input  wire logic sda_i,
  output logic      scl,
  output logic      sda_lo
);
  // Idle bus: clock high, data released
  initial begin
    scl    = 1'b1;
    sda_lo = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One bit at 400 kbit/s: 150 clocks low, 100 high; data moves while low
  task automatic bit_io(input logic b, output logic r);
    w(75);
    sda_lo <= ~b;
    w(75);
    scl    <= 1'b1;
    w(100);
    r      = sda_i;
    scl    <= 1'b0;
  endtask
  task automatic start;
    w(75);
    sda_lo <= 1'b1;
    w(100);
    scl    <= 1'b0;
  endtask
  task automatic stop;
    w(75);
    sda_lo <= 1'b1;
    w(75);
    scl    <= 1'b1;
    w(100);
    sda_lo <= 1'b0;
    w(100);
  endtask
  // Byte out MSB first, ninth bit released: read NACK or ack sample
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic acked);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(1'b1, r);
    acked = ~r;
  endtask
endmodule

// *** tb_top.sv ***
/*
  Self-checking bench for the common voltage serial port.
  Assumes the master model drives scl and pulls sda low only.
*/
`timescale 1ns/1ps
module tb_top
  import vcsp_pkg::*;
;
  logic       clk;
  logic       resetn;
  logic       scl;
  logic       sda_lo;
  logic       sda_oe;
  logic       sda_dout;
  logic [6:0] code;
  logic       busy;
  wire        sda = ~sda_lo & (sda_oe ? sda_dout : 1'b1);
  int         mismatches;
  int         num_checks;
  localparam logic [7:0] WA = {VCSP_SLAVE_ADDR, 1'b0};
  localparam logic [7:0] RA = {VCSP_SLAVE_ADDR, 1'b1};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  vcsp_master m (.clk(clk), .sda_i(sda), .scl(scl), .sda_lo(sda_lo));
  vcsp_top #(.NV_WRITE_CYC(5000)) dut (
    .clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_dout),
    .sda_oe(sda_oe), .common_voltage_code(code), .busy(busy));

  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One framed transfer: address, then one byte if acknowledged
  task automatic txn(input logic [7:0] a, input logic [7:0] d, output logic [7:0] rx,
                     output logic aa, output logic da);
    m.start();
    m.xfer(a, rx, aa);
    da = 1'b0;
    if (aa)
      m.xfer(d, rx, da);
    m.stop();
  endtask
  task automatic t_volatile;
    logic [7:0] rx;
    logic aa, da;
    txn(WA, 8'hef, rx, aa, da);
    check("wr addr ack", {7'h00, aa}, 8'h01);
    check("wr data ack", {7'h00, da}, 8'h01);
    check("code", {1'b0, code}, 8'h77);
    check("busy", {7'h00, busy}, 8'h00);
    txn(RA, 8'hff, rx, aa, da);
    check("rd byte", rx, 8'hef);
  endtask
  task automatic t_both;
    logic [7:0] rx;
    logic aa, da;
    txn(WA, 8'hee, rx, aa, da);
    check("busy", {7'h00, busy}, 8'h01);
    txn(RA, 8'hff, rx, aa, da);
    check("busy ack", {7'h00, aa}, 8'h00);
    for (int i = 0; i < 10000 && busy !== 1'b0; i++)
      @(posedge clk);
    check("busy done", {7'h00, busy}, 8'h00);
    txn(RA, 8'hff, rx, aa, da);
    check("rd byte", rx, 8'hee);
  endtask
  task automatic t_other;
    logic [7:0] rx;
    logic aa, da;
    txn(8'h9c, 8'h00, rx, aa, da);
    check("foreign ack", {7'h00, aa}, 8'h00);
    check("code", {1'b0, code}, 8'h77);
    // A second data byte in one write is neither acked nor taken
    m.start();
    m.xfer(WA, rx, aa);
    m.xfer(8'h01, rx, da);
    check("wr data ack", {7'h00, da}, 8'h01);
    m.xfer(8'h55, rx, da);
    m.stop();
    check("extra ack", {7'h00, da}, 8'h00);
    check("code", {1'b0, code}, 8'h00);
    check("busy", {7'h00, busy}, 8'h00);
    txn(RA, 8'hff, rx, aa, da);
    check("rd byte", rx, 8'h01);
  endtask
  // Reset, scenarios, verdict
  initial begin
    resetn     = 1'b0;
    mismatches = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    check("reset code", {1'b0, code}, {1'b0, VCSP_CODE_RESET});
    check("reset busy", {7'h00, busy}, 8'h00);
    check("reset oe", {7'h00, sda_oe}, 8'h00);
    t_volatile();
    t_both();
    t_other();
    give_verdict();
  end
  // Watchdog
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule
